//--- inc/plc_regs.svh
`ifndef PLC_REGS_SVH
`define PLC_REGS_SVH

// ----------------------------------------------------------------
// Sizes of the equation store and the operand spaces.
// ----------------------------------------------------------------
`define PLC_EQ_DEPTH 512
`define PLC_EQ_LAST 9'h1FF
`define PLC_NUM_TMR 32
`define PLC_NUM_VOUT 64
`define PLC_NUM_IN 64
`define PLC_NUM_LATCH 16
`define PLC_NUM_AN 8
`define PLC_STACK_W 16

// ----------------------------------------------------------------
// Entry layout: opcode in the top nibble, argument below it.
// ----------------------------------------------------------------
`define PLC_OP_MSB 11
`define PLC_OP_LSB 8
`define PLC_ARG_MSB 7
`define PLC_ARG_LSB 0

// ----------------------------------------------------------------
// Opcodes. The reset value of every entry is the end marker.
// ----------------------------------------------------------------
`define PLC_OP_END 4'h0
`define PLC_OP_ON 4'h1
`define PLC_OP_OFF 4'h2
`define PLC_OP_IN 4'h3
`define PLC_OP_VO 4'h4
`define PLC_OP_NOT 4'h5
`define PLC_OP_AND 4'h6
`define PLC_OP_OR 4'h7
`define PLC_OP_XOR 4'h8
`define PLC_OP_LATCH 4'h9
`define PLC_OP_TMR 4'hA
`define PLC_OP_CMP 4'hB
`define PLC_OP_SET 4'hC

// ----------------------------------------------------------------
// Timing: a 1 ms fine tick, which also starts each pass.
// ----------------------------------------------------------------
`define PLC_CLK_HZ 10000000
`define PLC_TICK_US 1000
`define PLC_TICK_CYC (`PLC_CLK_HZ / 1000000 * `PLC_TICK_US)
`define PLC_COARSE_TICKS 7'h64
`define PLC_HYS_FULL 8'h64

`endif

//--- inc/plc_pkg.sv
package plc_pkg;
    typedef enum logic [1:0] {
        S_CLEAR,
        S_IDLE,
        S_RUN
    } plc_state_e;
    typedef logic [11:0] plc_entry_t;
    typedef logic [15:0] plc_delay_t;
    typedef logic signed [15:0] plc_analog_t;
    typedef logic [2:0] plc_atype_t;
endpackage

//--- design/plc_timer.sv
`timescale 1ns/1ps
module plc_timer (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // Time base.
    input wire logic i_tick_fine,
    input wire logic i_tick_coarse,
    input wire logic i_unit,
    // Delays in ticks of the chosen unit.
    input wire plc_pkg::plc_delay_t i_pickup,
    input wire plc_pkg::plc_delay_t i_dropout,
    // Qualified signal.
    input wire logic i_in,
    output logic o_out
);
    import plc_pkg::*;

    logic [15:0] cnt_q;
    logic out_q;

    // The unit setting picks which tick advances the count.
    wire tick = i_unit ? i_tick_coarse : i_tick_fine;
    wire [15:0] lim = i_in ? i_pickup : i_dropout;
    wire moving = i_in != out_q;
    wire [15:0] cnt_inc = 16'(cnt_q + 16'h1);
    // A zero delay changes the output at the next edge.
    wire done = (lim == 16'h0) || (tick && cnt_inc >= lim);

    // The count restarts whenever the input returns to the output level.
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_q <= 16'h0;
            out_q <= 1'b0;
        end else if (!moving) begin
            cnt_q <= 16'h0;
        end else if (done) begin
            out_q <= i_in;
            cnt_q <= 16'h0;
        end else if (tick) begin
            cnt_q <= cnt_inc;
        end
    end

    assign o_out = out_q;
endmodule

//--- design/plc_top.sv
// What this block does
// - 512 entries, all reset to end marker.
// - Pass runs entries in order until end.
// - Disabled element never yields a one.
// - Unassigned virtual outputs read previous value.
// - Thirty-two timers usable as equation operators.
// - Timer type picks its delay unit.
// - Output rises after input true pickup delay.
// - Output falls after input false dropout delay.
// - Signal is plus input minus minus input.
// - No input selected means no output.
// - Mismatched input types block operation.
// - Signed or absolute difference selectable.
// - Level or rate-of-change comparison selectable.
// - Over or under direction sets pickup.
// - Dropout band is percent of pickup.
// - Signed arithmetic handles negative values.
// - Pickup held in per-unit of type base.
// - Rate interval and unit used only delta.
// - Assert delay and reset delay qualify output.
// - Whole list evaluated every millisecond.
`timescale 1ns/1ps
`include "plc_regs.svh"
module plc_top #(
    parameter int P_TICK_CYC = `PLC_TICK_CYC
) (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // Equation store write port.
    input wire logic i_eq_wr_en,
    input wire logic [8:0] i_eq_wr_addr,
    input wire plc_pkg::plc_entry_t i_eq_wr_data,
    // Logic operands from outside.
    input wire logic [63:0] i_logic_in,
    // Timer settings, sixteen bits per timer for delays.
    input wire logic [31:0] i_timer_enable,
    input wire logic [31:0] i_timer_type,
    input wire logic [511:0] i_timer_pickup,
    input wire logic [511:0] i_timer_dropout,
    // Analog values, per-unit, and their type codes.
    input wire logic [127:0] i_analog_value,
    input wire logic [23:0] i_analog_type,
    // Comparator settings.
    input wire logic i_cmp_enable,
    input wire logic [3:0] i_cmp_pos_sel,
    input wire logic [3:0] i_cmp_neg_sel,
    input wire logic i_cmp_absolute,
    input wire logic i_cmp_delta,
    input wire logic i_cmp_under,
    input wire plc_pkg::plc_analog_t i_cmp_pickup,
    input wire logic [7:0] i_cmp_hysteresis,
    input wire logic i_rate_interval_unit,
    input wire plc_pkg::plc_delay_t i_rate_interval_length,
    input wire plc_pkg::plc_delay_t i_comparator_assert_delay,
    input wire plc_pkg::plc_delay_t i_cmp_reset_delay,
    // Results.
    output logic [63:0] o_virtual_output,
    output logic o_cmp_operate,
    output logic o_pass_busy,
    output logic o_pass_done
);
    import plc_pkg::*;

    // ----------------------------------------------------------------
    // Time base
    // ----------------------------------------------------------------
    logic [15:0] div_q;
    logic [6:0] coarse_q;
    logic tick_ms_q;
    logic tick_hms_q;

    wire div_end = div_q == 16'(P_TICK_CYC - 1);
    wire coarse_end = coarse_q == 7'(`PLC_COARSE_TICKS - 7'h1);

    // Fine tick every millisecond, coarse tick every hundred of them.
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            div_q <= 16'h0;
            coarse_q <= 7'h0;
            tick_ms_q <= 1'b0;
            tick_hms_q <= 1'b0;
        end else begin
            div_q <= div_end ? 16'h0 : 16'(div_q + 16'h1);
            tick_ms_q <= div_end;
            tick_hms_q <= div_end && coarse_end;
            if (div_end) begin
                coarse_q <= coarse_end ? 7'h0 : 7'(coarse_q + 7'h1);
            end
        end
    end

    // ----------------------------------------------------------------
    // Equation store and sequencer
    // ----------------------------------------------------------------
    plc_entry_t eq_mem [`PLC_EQ_DEPTH];
    plc_state_e state_q;
    logic [8:0] pc_q;
    logic [`PLC_STACK_W-1:0] stk_q;
    logic [`PLC_STACK_W-1:0] stk_d;
    logic [63:0] vwork_q;
    logic [63:0] vwork_d;
    logic [`PLC_NUM_LATCH-1:0] latch_q;
    logic [31:0] tmr_in_q;
    logic [31:0] tmr_out;
    logic cmp_raw_q;
    logic cmp_qual;

    wire running = state_q == S_RUN;
    wire clearing = state_q == S_CLEAR;
    wire plc_entry_t entry = eq_mem[pc_q];
    wire [3:0] op = entry[`PLC_OP_MSB:`PLC_OP_LSB];
    wire [7:0] arg = entry[`PLC_ARG_MSB:`PLC_ARG_LSB];
    wire [3:0] cnt_n = arg[3:0];
    wire at_end = op == `PLC_OP_END;
    wire last_entry = at_end || pc_q == `PLC_EQ_LAST;

    // While clearing, the store ignores the write port.
    wire mem_we = clearing || i_eq_wr_en;
    wire [8:0] mem_wa = clearing ? pc_q : i_eq_wr_addr;
    wire plc_entry_t mem_wd = clearing ? {`PLC_OP_END, 8'h00} : i_eq_wr_data;

    // The store has no reset; the clear walk fills it after reset.
    always_ff @(posedge i_core_clk) begin
        if (mem_we) begin
            eq_mem[mem_wa] <= mem_wd;
        end
    end

    // Gate operands: n-input masks over the top of the stack.
    wire [15:0] nmask = 16'((17'h1 << cnt_n) - 17'h1);
    wire and_r = (stk_q & nmask) == nmask;
    wire or_r = |(stk_q & nmask);
    wire xor_r = ^(stk_q & nmask);
    wire [15:0] popn = stk_q >> cnt_n;
    wire lat_s = stk_q[1];
    wire lat_r = stk_q[0];
    wire lat_n = !lat_r && (lat_s || latch_q[arg[3:0]]);
    // A disabled timer leaves a zero on top; a disabled comparator pushes a zero.
    wire tmr_val = tmr_out[arg[4:0]] && i_timer_enable[arg[4:0]];
    wire cmp_val;

    // One entry per cycle; the stack's top is bit zero.
    always_comb begin
        stk_d = stk_q;
        case (op)
            `PLC_OP_ON: stk_d = {stk_q[14:0], 1'b1};
            `PLC_OP_OFF: stk_d = {stk_q[14:0], 1'b0};
            `PLC_OP_IN: stk_d = {stk_q[14:0], i_logic_in[arg[5:0]]};
            `PLC_OP_VO: stk_d = {stk_q[14:0], vwork_q[arg[5:0]]};
            `PLC_OP_NOT: stk_d = {stk_q[15:1], !stk_q[0]};
            `PLC_OP_AND: stk_d = {popn[14:0], and_r};
            `PLC_OP_OR: stk_d = {popn[14:0], or_r};
            `PLC_OP_XOR: stk_d = {popn[14:0], xor_r};
            `PLC_OP_LATCH: stk_d = {1'b0, stk_q[15:2], lat_n};
            `PLC_OP_TMR: stk_d = {stk_q[15:1], tmr_val};
            `PLC_OP_CMP: stk_d = {stk_q[14:0], cmp_val};
            `PLC_OP_SET: stk_d = {1'b0, stk_q[15:1]};
            default: stk_d = stk_q;
        endcase
    end

    // Assignments land in the working copy only.
    always_comb begin
        vwork_d = vwork_q;
        if (running && op == `PLC_OP_SET) begin
            vwork_d[arg[5:0]] = stk_q[0];
        end
    end

    // Sequencer: clear walk, then one pass per fine tick.
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= S_CLEAR;
            pc_q <= 9'h000;
            stk_q <= 16'h0000;
        end else begin
            case (state_q)
                S_CLEAR: begin
                    pc_q <= 9'(pc_q + 9'h001);
                    if (pc_q == `PLC_EQ_LAST) begin
                        state_q <= S_IDLE;
                    end
                end
                S_IDLE: begin
                    pc_q <= 9'h000;
                    stk_q <= 16'h0000;
                    if (tick_ms_q) begin
                        state_q <= S_RUN;
                    end
                end
                S_RUN: begin
                    stk_q <= stk_d;
                    pc_q <= 9'(pc_q + 9'h001);
                    if (last_entry) begin
                        state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // Operator state: latches, timer inputs and working outputs.
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            latch_q <= 16'h0000;
            tmr_in_q <= 32'h0000_0000;
            vwork_q <= 64'h0;
        end else if (running) begin
            vwork_q <= vwork_d;
            if (op == `PLC_OP_LATCH) begin
                latch_q[arg[3:0]] <= lat_n;
            end
            if (op == `PLC_OP_TMR) begin
                tmr_in_q[arg[4:0]] <= stk_q[0] && i_timer_enable[arg[4:0]];
            end
        end
    end

    // Virtual outputs become visible only when the pass finishes; the comparator output follows every cycle.
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_virtual_output <= 64'h0;
            o_pass_busy <= 1'b0;
            o_pass_done <= 1'b0;
            o_cmp_operate <= 1'b0;
        end else begin
            o_pass_busy <= running && !last_entry;
            o_pass_done <= running && last_entry;
            o_cmp_operate <= cmp_val;
            if (running && last_entry) begin
                o_virtual_output <= vwork_d;
            end
        end
    end

    // ----------------------------------------------------------------
    // General timers
    // ----------------------------------------------------------------
    // Each timer follows the input captured by its last operator use.
    for (genvar g = 0; g < `PLC_NUM_TMR; g++) begin : g_tmr
        plc_timer u_tmr (
            .i_core_clk(i_core_clk),
            .i_rstn(i_rstn),
            .i_tick_fine(tick_ms_q),
            .i_tick_coarse(tick_hms_q),
            .i_unit(i_timer_type[g]),
            .i_pickup(i_timer_pickup[g*16 +: 16]),
            .i_dropout(i_timer_dropout[g*16 +: 16]),
            .i_in(tmr_in_q[g]),
            .o_out(tmr_out[g])
        );
    end

    // ----------------------------------------------------------------
    // Comparator
    // ----------------------------------------------------------------
    wire pos_on = i_cmp_pos_sel != 4'h0;
    wire neg_on = i_cmp_neg_sel != 4'h0;
    wire [2:0] pos_i = 3'(i_cmp_pos_sel - 4'h1);
    wire [2:0] neg_i = 3'(i_cmp_neg_sel - 4'h1);
    wire plc_analog_t pos_v = pos_on ? i_analog_value[pos_i*16 +: 16] : 16'sh0000;
    wire plc_analog_t neg_v = neg_on ? i_analog_value[neg_i*16 +: 16] : 16'sh0000;
    wire plc_atype_t pos_t = i_analog_type[pos_i*3 +: 3];
    wire plc_atype_t neg_t = i_analog_type[neg_i*3 +: 3];
    wire any_on = pos_on || neg_on;
    wire type_bad = pos_on && neg_on && pos_t != neg_t;
    wire cmp_valid = i_cmp_enable && any_on && !type_bad;
    // Gated by validity too, so a late delay output never leaks through.
    assign cmp_val = cmp_qual && cmp_valid;

    // Off inputs already read as zero, so the difference is plain.
    wire signed [17:0] diff = 18'(pos_v) - 18'(neg_v);
    wire signed [17:0] sig = (i_cmp_absolute && diff < 0) ? -diff : diff;

    // Rate of change: the change over one programmed interval.
    logic signed [17:0] prev_q;
    logic signed [17:0] delta_q;
    logic [15:0] ivl_q;
    wire ivl_tick = i_rate_interval_unit ? tick_hms_q : tick_ms_q;
    wire [15:0] ivl_inc = 16'(ivl_q + 16'h1);
    wire ivl_end = ivl_tick && ivl_inc >= i_rate_interval_length;

    // The interval only runs in delta mode; level mode ignores it.
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            prev_q <= 18'sh0;
            delta_q <= 18'sh0;
            ivl_q <= 16'h0;
        end else if (!i_cmp_delta) begin
            ivl_q <= 16'h0;
            prev_q <= sig;
            delta_q <= 18'sh0;
        end else if (ivl_end) begin
            ivl_q <= 16'h0;
            prev_q <= sig;
            delta_q <= 18'(sig - prev_q);
        end else if (ivl_tick) begin
            ivl_q <= ivl_inc;
        end
    end

    // Operating value in the same per-unit scale as the pickup.
    wire signed [17:0] oper = i_cmp_delta ? delta_q : sig;
    wire signed [17:0] pkp = 18'(i_cmp_pickup);
    wire [16:0] pkp_mag = 17'(pkp < 0 ? -pkp : pkp);
    wire [24:0] band_x = 25'(pkp_mag) * 25'(i_cmp_hysteresis);
    wire [17:0] band = 18'(band_x / 25'(`PLC_HYS_FULL));
    wire signed [18:0] drop_lo = 19'(pkp) - 19'(band);
    wire signed [18:0] drop_hi = 19'(pkp) + 19'(band);
    wire over_pu = oper > pkp;
    wire under_pu = oper < pkp;
    wire over_dr = 19'(oper) < drop_lo;
    wire under_dr = 19'(oper) > drop_hi;
    wire pu_hit = i_cmp_under ? under_pu : over_pu;
    wire dr_hit = i_cmp_under ? under_dr : over_dr;

    // Raw state is re-judged at the start of every pass.
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cmp_raw_q <= 1'b0;
        end else if (!cmp_valid) begin
            cmp_raw_q <= 1'b0;
        end else if (tick_ms_q) begin
            cmp_raw_q <= cmp_raw_q ? !dr_hit : pu_hit;
        end
    end

    // Assert and reset delays reuse the timer, counted in ms.
    plc_timer u_cmp_dly (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_tick_fine(tick_ms_q),
        .i_tick_coarse(tick_hms_q),
        .i_unit(1'b0),
        .i_pickup(i_comparator_assert_delay),
        .i_dropout(i_cmp_reset_delay),
        .i_in(cmp_raw_q),
        .o_out(cmp_qual)
    );
endmodule

//--- tb/plc_top_assertions.sv
`timescale 1ns/1ps
module plc_top_assertions #(
    parameter int P_TICK_CYC = 20
) (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // Comparator settings.
    input wire logic [23:0] i_analog_type,
    input wire logic i_cmp_enable,
    input wire logic [3:0] i_cmp_pos_sel,
    input wire logic [3:0] i_cmp_neg_sel,
    // Results.
    input wire logic [63:0] o_virtual_output,
    input wire logic o_cmp_operate,
    input wire logic o_pass_busy,
    input wire logic o_pass_done
);
    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    logic busy_q;
    logic seen_q;
    logic [15:0] gap_q;
    logic [2:0] ch_p;
    logic [2:0] ch_n;
    logic sel_any;
    logic ty_ok;
    logic pass_start;

    // A type mismatch only blocks the comparator when both inputs are in use.
    assign ch_p = i_cmp_pos_sel[2:0] - 3'h1;
    assign ch_n = i_cmp_neg_sel[2:0] - 3'h1;
    assign sel_any = (i_cmp_pos_sel != 4'h0) || (i_cmp_neg_sel != 4'h0);
    assign ty_ok = (i_cmp_pos_sel == 4'h0) || (i_cmp_neg_sel == 4'h0)
        || (i_analog_type[ch_p * 3 +: 3] == i_analog_type[ch_n * 3 +: 3]);
    assign pass_start = o_pass_busy && !busy_q;

    // Cycles between pass starts, so the pass rate is checked to the cycle.
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            busy_q <= 1'b0;
            seen_q <= 1'b0;
            gap_q <= 16'h0000;
        end else begin
            busy_q <= o_pass_busy;
            seen_q <= seen_q || pass_start;
            gap_q <= pass_start ? 16'h0001 : gap_q + 16'h0001;
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rstn);

    sequence pass_end_s;
        o_pass_done && !o_pass_busy;
    endsequence

    reset_clear_a: assert property (
        $rose(i_rstn) |-> (o_virtual_output == 64'h0 && !o_cmp_operate && !o_pass_busy) [*8]
    ) else $error("outputs not idle after reset");
    out_publish_a: assert property (
        !$stable(o_virtual_output) |-> pass_end_s
    ) else $error("virtual outputs changed outside a pass end");
    done_pulse_a: assert property (
        pass_end_s |=> !o_pass_done [*3]
    ) else $error("pass done is not a single pulse");
    busy_end_a: assert property (
        $fell(o_pass_busy) |-> pass_end_s
    ) else $error("pass busy fell without pass done");
    pass_rate_a: assert property (
        pass_start && seen_q |-> gap_q == P_TICK_CYC
    ) else $error("pass start spacing wrong");
    cmp_enable_a: assert property (
        $rose(o_cmp_operate) |-> $past(i_cmp_enable)
    ) else $error("disabled comparator operated");
    cmp_select_a: assert property (
        $rose(o_cmp_operate) |-> $past(sel_any)
    ) else $error("comparator operated with no input");
    cmp_type_a: assert property (
        $rose(o_cmp_operate) |-> $past(ty_ok)
    ) else $error("comparator operated on mixed types");
endmodule

bind plc_top plc_top_assertions #(
    .P_TICK_CYC(P_TICK_CYC)
) plc_top_assertions_inst (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_analog_type(i_analog_type),
    .i_cmp_enable(i_cmp_enable),
    .i_cmp_pos_sel(i_cmp_pos_sel),
    .i_cmp_neg_sel(i_cmp_neg_sel),
    .o_virtual_output(o_virtual_output),
    .o_cmp_operate(o_cmp_operate),
    .o_pass_busy(o_pass_busy),
    .o_pass_done(o_pass_done)
);

//--- tb/plc_top_test.sv
`timescale 1ns/1ps
module plc_top_test;
    import plc_pkg::*;
    localparam int P_TICK_CYC = 20;
    // ----------------------------------------
    // Design ports
    // ----------------------------------------
    logic i_core_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_eq_wr_en = 1'b0;
    logic [8:0] i_eq_wr_addr = 9'h000;
    plc_entry_t i_eq_wr_data = 12'h000;
    logic [63:0] i_logic_in = '0;
    logic [31:0] i_timer_enable = 32'hFFFFFFFF;
    logic [31:0] i_timer_type = '0;
    logic [511:0] i_timer_pickup = '0;
    logic [511:0] i_timer_dropout = '0;
    logic [127:0] i_analog_value = '0;
    logic [23:0] i_analog_type = '0;
    logic i_cmp_enable = 1'b0;
    logic [3:0] i_cmp_pos_sel = 4'h0;
    logic [3:0] i_cmp_neg_sel = 4'h0;
    logic i_cmp_absolute = 1'b0;
    logic i_cmp_delta = 1'b0;
    logic i_cmp_under = 1'b0;
    plc_analog_t i_cmp_pickup = 16'h0000;
    logic [7:0] i_cmp_hysteresis = 8'h00;
    logic i_rate_interval_unit = 1'b0;
    plc_delay_t i_rate_interval_length = 16'h0001;
    plc_delay_t i_comparator_assert_delay = 16'h0000;
    plc_delay_t i_cmp_reset_delay = 16'h0000;
    logic [63:0] o_virtual_output;
    logic o_cmp_operate;
    logic o_pass_busy;
    logic o_pass_done;
    int fail_count = 0;
    int tests_run = 0;
    logic [31:0] seed = 32'h00000020;
    int a0 = 0;
    int a1 = 0;

    plc_top #(.P_TICK_CYC(P_TICK_CYC)) plc_top_inst (
        .i_core_clk, .i_rstn, .i_eq_wr_en, .i_eq_wr_addr, .i_eq_wr_data, .i_logic_in,
        .i_timer_enable, .i_timer_type, .i_timer_pickup, .i_timer_dropout, .i_analog_value,
        .i_analog_type, .i_cmp_enable, .i_cmp_pos_sel, .i_cmp_neg_sel, .i_cmp_absolute,
        .i_cmp_delta, .i_cmp_under, .i_cmp_pickup, .i_cmp_hysteresis, .i_rate_interval_unit,
        .i_rate_interval_length, .i_comparator_assert_delay, .i_cmp_reset_delay,
        .o_virtual_output, .o_cmp_operate, .o_pass_busy, .o_pass_done
    );
    // Core clock, 100 ns period.
    always #50 i_core_clk = ~i_core_clk;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic print_verdict();
        if (fail_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] want);
        tests_run++;
        if (seen !== want) begin
            fail_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Holds the write strobe across the whole program so it is never pulsed twice in one step.
    task automatic prog(input plc_entry_t p[$]);
        foreach (p[k]) begin
            i_eq_wr_en <= 1'b1;
            i_eq_wr_addr <= 9'(k);
            i_eq_wr_data <= p[k];
            @(posedge i_core_clk);
        end
        i_eq_wr_en <= 1'b0;
    endtask

    task automatic pass(input int n);
        int c;
        repeat (n) begin
            c = 0;
            do begin
                @(negedge i_core_clk);
                c++;
            end while (o_pass_done !== 1'b1 && c < 700);
            if (c >= 700) begin
                fail_count++;
                print_verdict();
            end
        end
        @(posedge i_core_clk);
    endtask

    // Cycles until a virtual output, or the comparator when idx is 64, reaches a level.
    task automatic lag(input int idx, input logic lvl, output int c);
        c = 0;
        do begin
            @(negedge i_core_clk);
            c++;
        end while ((idx == 64 ? o_cmp_operate : o_virtual_output[idx[5:0]]) !== lvl && c < 5000);
        if (c >= 5000) begin
            fail_count++;
            print_verdict();
        end
        @(posedge i_core_clk);
    endtask

    // The delay window allows a partial first tick and up to three ticks of pass lag.
    task automatic win(input int c, input int d, input int u);
        chk(64'(c >= (d > 0 ? (d - 1) * u : 0) && c <= d * u + 3 * P_TICK_CYC), 64'h1);
    endtask

    task automatic do_reset();
        i_rstn <= 1'b0;
        repeat (6) @(posedge i_core_clk);
        chk({o_cmp_operate, o_pass_busy, o_pass_done}, 64'h0);
        chk(o_virtual_output, 64'h0);
        i_rstn <= 1'b1;
    endtask

    function automatic logic [4:0] lexp(input logic [63:0] x);
        return {1'b0, x[2] | x[3], ~x[2], x[2] ^ x[3], x[2] & x[3]};
    endfunction

    function automatic logic cmp_exp();
        int op;
        logic [2:0] tp;
        logic [2:0] tn;
        op = (i_cmp_pos_sel == 4'h1 ? a0 : i_cmp_pos_sel == 4'h2 ? a1 : 0)
            - (i_cmp_neg_sel == 4'h1 ? a0 : i_cmp_neg_sel == 4'h2 ? a1 : 0);
        tp = i_cmp_pos_sel == 4'h2 ? i_analog_type[5:3] : i_analog_type[2:0];
        tn = i_cmp_neg_sel == 4'h2 ? i_analog_type[5:3] : i_analog_type[2:0];
        if (i_cmp_absolute && op < 0) begin
            op = -op;
        end
        if (i_cmp_delta) begin
            op = 0;
        end
        if (!i_cmp_enable || i_cmp_pos_sel + i_cmp_neg_sel == 4'h0
            || (i_cmp_pos_sel * i_cmp_neg_sel != 4'h0 && tp != tn)) begin
            return 1'b0;
        end
        return i_cmp_under ? op < int'(i_cmp_pickup) : op > int'(i_cmp_pickup);
    endfunction

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        int c;
        int tt[3] = '{31, 0, 5};
        int ty[3] = '{0, 0, 1};
        int tp[3] = '{3, 0, 2};
        int td[3] = '{2, 0, 1};
        int hv[8] = '{1001, 900, 899, 999, -1001, -800, -799, -1000};
        do_reset();
        repeat (520) @(posedge i_core_clk); // Writes during the clear walk are lost.
        prog('{12'h100, 12'h200, 12'h900, 12'hC00});
        pass(1);
        chk(o_virtual_output, 64'h1);
        prog('{12'h41E, 12'hC1F, 12'h100, 12'hC1E, 12'h000});
        pass(1);
        chk(o_virtual_output[31:30], 64'h1);
        pass(1);
        chk(o_virtual_output[31:30], 64'h3);
        prog('{12'h302, 12'h303, 12'h602, 12'hC14, 12'h302, 12'h303, 12'h802, 12'hC15, 12'h302,
            12'h500, 12'hC16, 12'h302, 12'h303, 12'h702, 12'hC17, 12'h000, 12'h100, 12'hC18});
        for (int k = 0; k < 8; k++) begin
            i_logic_in <= {rnd(), rnd()};
            pass(2);
            chk(o_virtual_output[24:20], lexp(i_logic_in));
        end
        i_timer_enable[7] <= 1'b0;
        i_logic_in <= 64'h2;
        prog('{12'h301, 12'hA07, 12'hC0B, 12'h000});
        pass(4);
        chk(o_virtual_output[11], 64'h0);
        i_logic_in <= 64'h0;
        for (int k = 0; k < 3; k++) begin
            i_timer_type[tt[k]] <= ty[k][0];
            i_timer_pickup[tt[k] * 16 +: 16] <= 16'(tp[k]);
            i_timer_dropout[tt[k] * 16 +: 16] <= 16'(td[k]);
            prog('{12'h301, {4'hA, 3'h0, 5'(tt[k])}, 12'hC0B, 12'h000});
            pass(2);
            i_logic_in <= 64'h2;
            lag(11, 1'b1, c);
            win(c, tp[k], ty[k] ? 100 * P_TICK_CYC : P_TICK_CYC);
            i_logic_in <= 64'h0;
            lag(11, 1'b0, c);
            win(c, td[k], ty[k] ? 100 * P_TICK_CYC : P_TICK_CYC);
        end
        prog('{12'hB00, 12'hC0C, 12'h000});
        for (int k = 0; k < 16; k++) begin
            a0 = int'(rnd() % 8000) * 2 - 8000;
            a1 = int'(rnd() % 8000) * 2 - 8000;
            i_analog_value[31:0] <= {16'(a1), 16'(a0)};
            i_analog_type[5:3] <= 3'(rnd() % 4 == 0);
            i_cmp_enable <= rnd() % 8 != 0;
            i_cmp_pos_sel <= 4'(rnd() % 3);
            i_cmp_neg_sel <= 4'(rnd() % 3);
            i_cmp_absolute <= 1'(rnd() % 2);
            i_cmp_delta <= rnd() % 4 == 0;
            i_cmp_under <= 1'(rnd() % 2);
            i_cmp_pickup <= 16'(int'(rnd() % 8000) * 2 - 7999);
            pass(6);
            if (i_cmp_delta) chk(o_cmp_operate, cmp_exp());
            else chk(o_cmp_operate, cmp_exp());
            chk(o_virtual_output[12], cmp_exp());
        end
        {i_cmp_enable, i_cmp_pos_sel, i_cmp_neg_sel, i_cmp_absolute, i_cmp_delta} <= {1'b1, 4'h1, 4'h0, 2'h0};
        i_analog_type <= '0;
        for (int k = 0; k < 8; k++) begin
            i_cmp_under <= k >= 4;
            i_cmp_pickup <= k < 4 ? 16'h03E8 : 16'hFC18;
            i_cmp_hysteresis <= k < 4 ? 8'h0A : 8'h14;
            i_analog_value[15:0] <= 16'(hv[k]);
            pass(4);
            if (k < 4) chk(o_cmp_operate, 64'(k % 4 < 2));
            else chk(o_cmp_operate, 64'(k % 4 < 2));
        end
        i_cmp_under <= 1'b0;
        i_cmp_pickup <= 16'h03E8;
        i_comparator_assert_delay <= 16'h0005;
        i_cmp_reset_delay <= 16'h0003;
        i_analog_value[15:0] <= 16'hFFFE;
        pass(3);
        i_analog_value[15:0] <= 16'h03EA;
        lag(64, 1'b1, c);
        win(c, 5, P_TICK_CYC);
        i_analog_value[15:0] <= 16'hFFFE;
        lag(64, 1'b0, c);
        win(c, 3, P_TICK_CYC);
        do_reset();
        pass(1);
        chk(o_virtual_output, 64'h0);
        print_verdict();
    end
endmodule
